// ---- logic/lock_holdover_cfg.svh ----
/*
  Offsets, field positions, reset values, codes and counts of the
  lock supervision and holdover block. Included by the design files.
*/
`ifndef LOCK_HOLDOVER_CFG_SVH
`define LOCK_HOLDOVER_CFG_SVH

// Register indices; the byte address is four times the index
`define IDX_PUMP_STATUS  6'h17
`define IDX_LOCK_DET     6'h18
`define IDX_LOCK_PIN     6'h1A
`define IDX_REF_MONITOR_PIN       6'h1B
`define IDX_HOLDOVER     6'h1D
`define IDX_STATE        6'h30
`define IDX_EXTRA        6'h31

// Field positions
`define F_ABP_LO         0
`define F_ABP_HI         1
`define F_STS_LO         2
`define F_STS_HI         7
`define F_CNT_LO         5
`define F_CNT_HI         6
`define F_WIN_RANGE      4
`define F_DLD_OFF        3
`define F_HO_EN0         0
`define F_HO_EXT         1
`define F_HO_EN2         2
`define F_CMP_EN         3
`define F_IGN_SYNC       8

// Reset values
`define RST_PUMP_STATUS  8'h00
`define RST_LOCK_DET     8'h00
`define RST_LOCK_PIN     6'h00
`define RST_REF_MONITOR_PIN       5'h00
`define RST_HOLDOVER     4'h0
`define RST_EXTRA        9'h010

// Lock pin output select codes
`define LP_DLD           6'h00
`define LP_ALD_N         6'h01
`define LP_ALD_P         6'h02
`define LP_CURRENT       6'h04

// Status and monitor pin select codes
`define SP_LOW           6'h00
`define SP_DLD           6'h01
`define SP_CMP_HI        6'h02
`define SP_CMP_LO        6'h03
`define SP_HIZ           6'h04

// Consecutive in-window cycles needed for lock, per count setting
`define LOCK_NEED_0      8'h05
`define LOCK_NEED_1      8'h10
`define LOCK_NEED_2      8'h40
`define LOCK_NEED_3      8'hFF

// Window widths in clock cycles
`define LOCK_THR_HIGH    8'h06
`define LOCK_THR_LOW     8'h02
`define UNLOCK_MARGIN    8'h04

`endif

// ---- logic/lock_holdover_pkg.sv ----
/*
  Types shared by the lock supervision and holdover block.
  Assumes nothing of its surroundings.
*/
package lock_holdover_pkg;

  // Holdover state, one-hot
  typedef enum logic [2:0] {
    HO_RUN      = 3'b001,
    HO_SYNC_LOW = 3'b010,
    HO_WAIT_REF = 3'b100
  } ho_state_t;

  typedef logic [7:0] cyc_cnt_t;

endpackage

// ---- logic/pin_sync.sv ----
/*
  Three-stage synchroniser for a pin from outside the clock domain.
  A change counts once the second and third stages agree.
  Assumes a free running clock and asynchronous active low reset.
*/
`timescale 1ns/10ps
module pin_sync #(
  parameter bit INIT = 1'b0
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  // Shift the pin through three stages
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
    end else begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Accept a new level only when stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level <= INIT;
      rise  <= 1'b0;
      fall  <= 1'b0;
    end else begin
      if (s2_reg == s3_reg) begin
        level <= s3_reg;
      end
      rise <= (s2_reg == s3_reg) && s3_reg && !level;
      fall <= (s2_reg == s3_reg) && !s3_reg && level;
    end
  end
endmodule // pin_sync

// ---- logic/lock_charge_counter.sv ----
/*
  Saturating counter standing for the charged lock pin capacitor
  and its comparator. Assumes the step and level inputs share clk.
*/
`timescale 1ns/10ps
module lock_charge_counter #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         step,
  input  wire logic         charging,
  input  wire logic [W-1:0] trip,
  output logic              tripped
);
  logic [W-1:0] count_reg;

  generate
    if (W < 2 || W > 16) begin : bad_width
      $error("lock_charge_counter: W must be 2 to 16");
    end
  endgenerate

  // Charge per comparison cycle, discharge at once
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else if (!charging) begin
      count_reg <= '0;
    end else if (step && count_reg != {W{1'b1}}) begin
      count_reg <= count_reg + 1'b1;
    end
  end

  // Comparator trips at the programmed level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tripped <= 1'b0;
    end else begin
      tripped <= charging && (count_reg >= trip);
    end
  end
endmodule // lock_charge_counter

// ---- logic/lock_holdover.sv ----
/*
  Lock supervision and holdover control: digital lock detector,
  lock pin modes, comparator model, manual and automatic holdover,
  and an APB register slave.
  Assumes phase comparator edges and the sync pin arrive from outside
  the pclk domain; pump requests come from logic on pclk.
*/
`timescale 1ns/10ps
`include "lock_holdover_cfg.svh"

// How it works
// - lock flag sets after programmed run of in-window comparison cycles
// - lock flag stays until one cycle exceeds the unlock window
// - unlock window is always wider than lock window
// - windows follow range bit, antibacklash setting and count setting
// - lock flag selectable on lock, status and monitor pins
// - lock pin offers pulse lock output in both polarities
// - current source mode chosen by lock pin select field
// - current source on while locked, pin shorted at once otherwise
// - comparator selectable, either polarity, on monitor and status pins
// - in holdover pump is high impedance with no up or down
// - holdover needs both enable bits set
// - sync falling edge enters manual holdover at once
// - pump leaves manual holdover only on next reference edge after sync high
// - feedback B counter resets as pump leaves holdover
// - distribution stops on sync low unless dividers ignore sync
// - automatic holdover enters on low sensed level, high if comparator off
// - a bit selects sync driven holdover over automatic
// - count setting zero needs five in-window cycles
module lock_holdover
  import lock_holdover_pkg::*;
#(
  parameter int CMP_W = 8
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       psel,
  input  wire logic       penable,
  input  wire logic       pwrite,
  input  wire logic [7:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]     prdata,
  output logic            pready,
  output logic            pslverr,
  input  wire logic       ref_edge_pin,
  input  wire logic       fb_edge_pin,
  input  wire logic       sync_n_pin,
  input  wire logic       pump_up_req,
  input  wire logic       pump_dn_req,
  output logic            pump_up,
  output logic            pump_dn,
  output logic            pump_hiz,
  output logic            b_counter_reset,
  output logic            dist_stop,
  output logic            lock_pin_o,
  output logic            lock_pin_oe_n,
  output logic            lock_pin_src,
  output logic            status_pin,
  output logic            ref_monitor_pin
);

  generate
    if (CMP_W < 2 || CMP_W > 8) begin : bad_cmp_width
      $error("lock_holdover: CMP_W must be 2 to 8");
    end
  endgenerate

  // Configuration registers
  logic [7:0]      pump_status_reg;
  logic [7:0]      lock_det_reg;
  logic [5:0]      lock_pin_sel_reg;
  logic [4:0]      ref_monitor_pin_sel_reg;
  logic [3:0]      holdover_reg;
  logic [8:0]      extra_reg;

  // Detector state
  logic            ref_rise;
  logic            fb_rise;
  logic            sync_level;
  logic            sync_fall;
  logic            meas_active_reg;
  logic            meas_ref_first_reg;
  cyc_cnt_t        diff_cnt_reg;
  cyc_cnt_t        run_cnt_reg;
  logic            phase_lock_flag_reg;
  logic            cmp_done;
  cyc_cnt_t        cmp_diff;
  cyc_cnt_t        lock_thr;
  cyc_cnt_t        unlock_thr;
  cyc_cnt_t        lock_need;
  logic            cmp_trip;
  logic            sensed_lock;
  logic            rearm_reg;
  ho_state_t       ho_state_reg;
  logic            ho_enabled;
  logic            hiz_now;

  // Bus decode
  logic            bus_setup_access;
  logic            bus_commit;
  logic [5:0]      reg_idx;
  logic            idx_hit;
  logic [31:0]     rd_value;

  // Pin synchronisers; reset levels match idle pins so no false edge follows reset
  pin_sync #(.INIT(1'b0)) ref_sync (.clk (pclk), .rst_n (presetn), .pin (ref_edge_pin),
    .level (), .rise (ref_rise), .fall ());
  pin_sync #(.INIT(1'b0)) fb_sync (.clk (pclk), .rst_n (presetn), .pin (fb_edge_pin),
    .level (), .rise (fb_rise), .fall ());
  pin_sync #(.INIT(1'b1)) sync_sync (.clk (pclk), .rst_n (presetn), .pin (sync_n_pin),
    .level (sync_level), .rise (), .fall (sync_fall));

  // APB: access phase takes two cycles, answer registered
  assign reg_idx          = paddr[7:2];
  assign bus_setup_access = psel && penable && !pready;
  assign bus_commit       = psel && penable && pready;

  always_comb begin
    idx_hit  = 1'b1;
    rd_value = 32'h0000_0000;
    unique case (reg_idx)
      `IDX_PUMP_STATUS: rd_value[7:0] = pump_status_reg;
      `IDX_LOCK_DET:    rd_value[7:0] = lock_det_reg;
      `IDX_LOCK_PIN:    rd_value[5:0] = lock_pin_sel_reg;
      `IDX_REF_MONITOR_PIN:      rd_value[4:0] = ref_monitor_pin_sel_reg;
      `IDX_HOLDOVER:    rd_value[3:0] = holdover_reg;
      `IDX_EXTRA:       rd_value[8:0] = extra_reg;
      `IDX_STATE:       rd_value[4:0] = {dist_stop, sensed_lock, pump_hiz,
                                         cmp_trip, phase_lock_flag_reg};
      default:          idx_hit = 1'b0;
    endcase
  end

  // Bus answer: ready, read data and error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= bus_setup_access;
      pslverr <= bus_setup_access && !idx_hit;
      if (bus_setup_access && !pwrite) begin
        prdata <= rd_value;
      end
    end
  end

  // Register writes take effect on the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pump_status_reg  <= `RST_PUMP_STATUS;
      lock_det_reg     <= `RST_LOCK_DET;
      lock_pin_sel_reg <= `RST_LOCK_PIN;
      ref_monitor_pin_sel_reg   <= `RST_REF_MONITOR_PIN;
      holdover_reg     <= `RST_HOLDOVER;
      extra_reg        <= `RST_EXTRA;
    end else if (bus_commit && pwrite) begin
      unique case (reg_idx)
        `IDX_PUMP_STATUS: pump_status_reg  <= pwdata[7:0];
        `IDX_LOCK_DET:    lock_det_reg     <= pwdata[7:0];
        `IDX_LOCK_PIN:    lock_pin_sel_reg <= pwdata[5:0];
        `IDX_REF_MONITOR_PIN:      ref_monitor_pin_sel_reg   <= pwdata[4:0];
        `IDX_HOLDOVER:    holdover_reg     <= pwdata[3:0];
        `IDX_EXTRA:       extra_reg        <= pwdata[8:0];
        default:          ;
      endcase
    end
  end

  // Window widths from range bit, antibacklash and count setting
  always_comb begin
    lock_thr = lock_det_reg[`F_WIN_RANGE] ? `LOCK_THR_LOW : `LOCK_THR_HIGH;
    lock_thr = lock_thr + {6'h00, pump_status_reg[`F_ABP_HI:`F_ABP_LO]};
    unlock_thr = lock_thr + `UNLOCK_MARGIN
                 + {6'h00, lock_det_reg[`F_CNT_HI:`F_CNT_LO]};
  end

  // Consecutive cycles needed for lock
  always_comb begin
    unique case (lock_det_reg[`F_CNT_HI:`F_CNT_LO])
      2'b00:   lock_need = `LOCK_NEED_0;
      2'b01:   lock_need = `LOCK_NEED_1;
      2'b10:   lock_need = `LOCK_NEED_2;
      2'b11:   lock_need = `LOCK_NEED_3;
      default: lock_need = `LOCK_NEED_0;
    endcase
  end

  // Measure cycles between the reference and feedback rising edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_active_reg    <= 1'b0;
      meas_ref_first_reg <= 1'b0;
      diff_cnt_reg       <= 8'h00;
    end else if (!meas_active_reg) begin
      if (ref_rise != fb_rise) begin
        meas_active_reg    <= 1'b1;
        meas_ref_first_reg <= ref_rise;
        diff_cnt_reg       <= 8'h01;
      end
    end else if (cmp_done) begin
      meas_active_reg <= 1'b0;
      diff_cnt_reg    <= 8'h00;
    end else if (diff_cnt_reg != 8'hFF) begin
      diff_cnt_reg <= diff_cnt_reg + 8'h01;
    end
  end

  // A comparison finishes when the second edge arrives
  always_comb begin
    cmp_done = 1'b0;
    cmp_diff = diff_cnt_reg;
    if (!meas_active_reg && ref_rise && fb_rise) begin
      cmp_done = 1'b1;
      cmp_diff = 8'h00;
    end else if (meas_active_reg) begin
      cmp_done = meas_ref_first_reg ? fb_rise : ref_rise;
    end
  end

  // Digital lock flag with consecutive-cycle counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_cnt_reg         <= 8'h00;
      phase_lock_flag_reg <= 1'b0;
    end else if (lock_det_reg[`F_DLD_OFF]) begin
      run_cnt_reg         <= 8'h00;
      phase_lock_flag_reg <= 1'b0;
    end else if (cmp_done) begin
      if (cmp_diff < lock_thr) begin
        run_cnt_reg <= run_cnt_reg + {7'h00, run_cnt_reg != 8'hFF};  // Saturates
        if (run_cnt_reg + 8'h01 >= lock_need) begin
          phase_lock_flag_reg <= 1'b1;
        end
      end else begin
        run_cnt_reg <= 8'h00;
        if (cmp_diff > unlock_thr) begin
          phase_lock_flag_reg <= 1'b0;
        end
      end
    end
  end

  // Comparator model on the charging lock pin
  lock_charge_counter #(.W(CMP_W)) charge_cnt (
    .clk      (pclk),
    .rst_n    (presetn),
    .step     (cmp_done),
    .charging (phase_lock_flag_reg),
    .trip     (extra_reg[CMP_W-1:0]),
    .tripped  (cmp_trip)
  );

  // Level sensed by automatic holdover
  assign sensed_lock = holdover_reg[`F_CMP_EN] ? cmp_trip : 1'b1;
  assign ho_enabled  = holdover_reg[`F_HO_EN0]
                       && holdover_reg[`F_HO_EN2];

  // Automatic holdover may re-enter only after lock is sensed again
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rearm_reg <= 1'b0;
    end else begin
      rearm_reg <= sensed_lock || (rearm_reg && ho_state_reg == HO_RUN);
    end
  end

  // Holdover state machine
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ho_state_reg <= HO_RUN;
    end else if (!ho_enabled) begin
      ho_state_reg <= HO_RUN;
    end else begin
      unique case (ho_state_reg)
        HO_RUN: begin
          if (holdover_reg[`F_HO_EXT] && sync_fall) begin
            ho_state_reg <= HO_SYNC_LOW;
          end else if (!holdover_reg[`F_HO_EXT] && !sensed_lock
                       && rearm_reg) begin
            ho_state_reg <= HO_WAIT_REF;
          end
        end
        HO_SYNC_LOW: if (sync_level) ho_state_reg <= HO_WAIT_REF;
        HO_WAIT_REF: if (ref_rise) ho_state_reg <= HO_RUN;
        default: ho_state_reg <= HO_RUN;
      endcase
    end
  end

  // Entry is seen the same cycle the edge is detected
  assign hiz_now = (ho_state_reg != HO_RUN)
                   || (ho_enabled && holdover_reg[`F_HO_EXT] && sync_fall);

  // Charge pump drive, B counter reset and distribution stop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pump_hiz        <= 1'b0;
      pump_up         <= 1'b0;
      pump_dn         <= 1'b0;
      b_counter_reset <= 1'b0;
      dist_stop       <= 1'b0;
    end else begin
      pump_hiz <= hiz_now && !(ho_state_reg == HO_WAIT_REF && ref_rise);
      pump_up  <= pump_up_req && !hiz_now;
      pump_dn  <= pump_dn_req && !hiz_now;
      b_counter_reset <= ho_enabled && ho_state_reg == HO_WAIT_REF
                         && ref_rise;
      dist_stop <= !sync_level && !extra_reg[`F_IGN_SYNC];
    end
  end

  // Lock pin drive; low enable means driving
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_pin_o    <= 1'b0;
      lock_pin_oe_n <= 1'b0;
      lock_pin_src  <= 1'b0;
    end else begin
      lock_pin_src <= 1'b0;
      unique case (lock_pin_sel_reg)
        `LP_DLD:     {lock_pin_o, lock_pin_oe_n} <= {phase_lock_flag_reg, 1'b0};
        `LP_ALD_N:   {lock_pin_o, lock_pin_oe_n} <= {1'b0, !meas_active_reg};
        `LP_ALD_P:   {lock_pin_o, lock_pin_oe_n} <= {1'b1, !meas_active_reg};
        `LP_CURRENT: begin
          {lock_pin_o, lock_pin_oe_n} <= {1'b0, phase_lock_flag_reg};
          lock_pin_src <= phase_lock_flag_reg;
        end
        default:     {lock_pin_o, lock_pin_oe_n} <= 2'b00;
      endcase
    end
  end

  // Status and monitor pin multiplexers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_pin      <= 1'b0;
      ref_monitor_pin <= 1'b0;
    end else begin
      unique case (pump_status_reg[`F_STS_HI:`F_STS_LO])
        `SP_DLD:    status_pin <= phase_lock_flag_reg;
        `SP_CMP_HI: status_pin <= cmp_trip;
        `SP_CMP_LO: status_pin <= !cmp_trip;
        `SP_HIZ:    status_pin <= pump_hiz;
        default:    status_pin <= 1'b0;
      endcase
      unique case ({1'b0, ref_monitor_pin_sel_reg})
        `SP_DLD:    ref_monitor_pin <= phase_lock_flag_reg;
        `SP_CMP_HI: ref_monitor_pin <= cmp_trip;
        `SP_CMP_LO: ref_monitor_pin <= !cmp_trip;
        `SP_HIZ:    ref_monitor_pin <= pump_hiz;
        default:    ref_monitor_pin <= 1'b0;
      endcase
    end
  end

endmodule // lock_holdover

// ---- dv/lock_holdover_assertions.sv ----
/* Port checker for lock_holdover.
   Assumes a bind onto every lock_holdover instance. */
`timescale 1ns/10ps
module lock_holdover_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ref_edge_pin,
  input wire logic sync_n_pin,
  input wire logic pump_up_req,
  input wire logic pump_up,
  input wire logic pump_dn,
  input wire logic pump_hiz,
  input wire logic b_counter_reset,
  input wire logic dist_stop
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Holdover and pump relations
  property p_quiet; pump_hiz |-> !pump_up && !pump_dn; endproperty
  a_quiet: assert property (p_quiet) else $error("pump active in hiz");
  property p_req; pump_up |-> $past(pump_up_req); endproperty
  a_req: assert property (p_req) else $error("pump up without request");
  property p_exit; b_counter_reset |-> !pump_hiz && $past(pump_hiz) ##1 !b_counter_reset;
  endproperty
  a_exit: assert property (p_exit) else $error("b reset off hiz exit");
  property p_hold; (pump_hiz && $stable(ref_edge_pin)) [*8] |=> pump_hiz; endproperty
  a_hold: assert property (p_hold) else $error("hiz left without ref");
  property p_dist; sync_n_pin [*8] |-> !dist_stop; endproperty
  a_dist: assert property (p_dist) else $error("dist stop with sync high");
  // Bus relations
  property p_wait; psel && $rose(penable) |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("pready late");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready too long");
  property p_err; pslverr |-> pready && psel && penable; endproperty
  a_err: assert property (p_err) else $error("pslverr outside access");
  c_hiz: cover property (pump_hiz ##1 !pump_hiz);
  c_bcnt: cover property (b_counter_reset);
  c_err: cover property (pslverr);
endmodule // lock_holdover_assertions

bind lock_holdover lock_holdover_assertions u_lock_holdover_assertions (
  .pclk, .presetn, .psel, .penable, .pready, .pslverr, .ref_edge_pin, .sync_n_pin,
  .pump_up_req, .pump_up, .pump_dn, .pump_hiz, .b_counter_reset, .dist_stop);

// ---- dv/lock_host_model.sv ----
/* Host side model: phase comparator edges and the sync pin.
   Assumes the bench sets run, delay and sync request. */
`timescale 1ns/10ps
module lock_host_model (
  input  wire logic       pclk,
  input  wire logic       run,
  input  wire logic       sync_req,
  input  wire logic [4:0] fb_delay,
  output logic            ref_edge_pin,
  output logic            fb_edge_pin,
  output logic            sync_n_pin
);
  logic [5:0] phase = 6'h00;
  initial ref_edge_pin = 1'b0;
  initial fb_edge_pin = 1'b0;
  initial sync_n_pin = 1'b1;
  // Period of 64 cycles, above any unlock window; edges stop when idle
  always @(posedge pclk) begin
    phase <= run ? phase + 6'h01 : 6'h00;
    ref_edge_pin <= run && (phase < 6'h04);
    fb_edge_pin <= run && ((phase - {1'b0, fb_delay}) < 6'h04);
    sync_n_pin <= !sync_req;
  end
endmodule // lock_host_model

// ---- dv/lock_holdover_bench.sv ----
/* Testbench of lock_holdover.
   Assumes the host model drives the phase and sync pins. */
`timescale 1ns/10ps
`include "lock_holdover_cfg.svh"
`define CHK(n, x, y) begin cmp_count++; if ((x) !== (y)) begin fails++; \
  $display("CHECK FAILED %s expected %0h seen %0h", n, x, y); end end
module lock_holdover_bench;
  localparam logic [7:0] A_STS = {`IDX_PUMP_STATUS, 2'b00};
  localparam logic [7:0] A_CNT = {`IDX_LOCK_DET, 2'b00};
  localparam logic [7:0] A_LP  = {`IDX_LOCK_PIN, 2'b00};
  localparam logic [7:0] A_MON = {`IDX_REF_MONITOR_PIN, 2'b00};
  localparam logic [7:0] A_HO  = {`IDX_HOLDOVER, 2'b00};
  localparam logic [7:0] A_ST  = {`IDX_STATE, 2'b00};
  localparam logic [7:0] A_EX  = {`IDX_EXTRA, 2'b00};
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e, run = 1'b0, sync_req = 1'b0, seen;
  logic pump_up_req = 1'b0, pump_dn_req = 1'b0, pump_up, pump_dn, pump_hiz;
  logic b_counter_reset, dist_stop, lock_pin_o, lock_pin_oe_n, lock_pin_src;
  logic status_pin, ref_monitor_pin, ref_edge_pin, fb_edge_pin, sync_n_pin;
  logic [4:0] fb_delay = 5'h00;
  int fails = 0, cmp_count = 0, cyc = 0;

  always #10 pclk = ~pclk;
  lock_holdover #(.CMP_W(8)) u_lock_holdover (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .ref_edge_pin, .fb_edge_pin, .sync_n_pin,
    .pump_up_req, .pump_dn_req, .pump_up, .pump_dn, .pump_hiz, .b_counter_reset,
    .dist_stop, .lock_pin_o, .lock_pin_oe_n, .lock_pin_src, .status_pin, .ref_monitor_pin);
  lock_host_model u_lock_host_model (.pclk, .run, .sync_req, .fb_delay, .ref_edge_pin,
    .fb_edge_pin, .sync_n_pin);

  // One bus transfer; result left in q and e
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // Wait for the answer; only the cycle ceiling ends a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic wait_per(input int n);
    repeat (n * 64) @(posedge pclk);
  endtask
  task automatic chk_flag(input logic x);
    apb(1'b0, A_ST, 32'h0);
    `CHK("lock flag", x, q[0])
  endtask

  task automatic t_regs;
    apb(1'b0, A_EX, 32'h0);
    `CHK("extra reset", {23'h0, `RST_EXTRA}, q)
    apb(1'b0, A_CNT, 32'h0);
    `CHK("lock det reset", {24'h0, `RST_LOCK_DET}, q)
    apb(1'b0, 8'h00, 32'h0);
    `CHK("unmapped err", 1'b1, e)
    `CHK("unmapped data", 32'h0, q)
    $display("test regs done");
  endtask

  task automatic t_lock;
    wr(A_STS, {24'h0, `SP_DLD, 2'b00});
    wr(A_MON, {26'h0, `SP_DLD});
    wr(A_CNT, 32'h10);
    fb_delay <= 5'h04;
    run <= 1'b1;
    wait_per(8);
    chk_flag(1'b0);
    wr(A_CNT, 32'h00);
    wait_per(2);
    chk_flag(1'b0);
    wait_per(6);
    chk_flag(1'b1);
    `CHK("status flag", 1'b1, status_pin)
    `CHK("monitor flag", 1'b1, ref_monitor_pin)
    `CHK("lock pin flag", 2'b10, {lock_pin_o, lock_pin_oe_n})
    fb_delay <= 5'h08;
    wait_per(4);
    chk_flag(1'b1);
    fb_delay <= 5'h0E;
    wait_per(2);
    chk_flag(1'b0);
    $display("test lock done");
  endtask

  // Pulse modes drive the pin only while a comparison runs
  task automatic t_pulse(input logic [5:0] sel, input logic lvl);
    int k;
    wr(A_LP, {26'h0, sel});
    wait_per(1);
    k = 0;
    repeat (64) begin
      @(posedge pclk);
      if (lock_pin_oe_n === 1'b0) begin
        k++;
      end
    end
    `CHK("pulse level", lvl, lock_pin_o)
    `CHK("pulse width", int'(fb_delay), k)
    $display("test pulse done");
  endtask

  task automatic t_cmp;
    wr(A_EX, 32'h4);
    wr(A_LP, {26'h0, `LP_CURRENT});
    wr(A_STS, {24'h0, `SP_CMP_LO, 2'b00});
    wr(A_MON, {26'h0, `SP_CMP_HI});
    fb_delay <= 5'h00;
    wait_per(12);
    apb(1'b0, A_ST, 32'h0);
    `CHK("cmp tripped", 1'b1, q[1])
    `CHK("source on", 1'b1, lock_pin_src)
    `CHK("status cmp low", 1'b0, status_pin)
    `CHK("monitor cmp", 1'b1, ref_monitor_pin)
    fb_delay <= 5'h0E;
    wait_per(2);
    apb(1'b0, A_ST, 32'h0);
    `CHK("cmp cleared", 1'b0, q[1])
    `CHK("source off", 1'b0, lock_pin_src)
    $display("test comparator done");
  endtask

  task automatic t_manual;
    wr(A_LP, {26'h0, `LP_DLD});
    wr(A_HO, 32'h7);
    wr(A_STS, {24'h0, `SP_HIZ, 2'b00});
    {pump_up_req, pump_dn_req, run} <= 3'b110;
    sync_req <= 1'b1;
    repeat (8) @(posedge pclk);
    `CHK("hiz on sync", 1'b1, pump_hiz)
    `CHK("status hiz", 1'b1, status_pin)
    `CHK("pump gated", 1'b0, pump_up | pump_dn)
    `CHK("dist stopped", 1'b1, dist_stop)
    sync_req <= 1'b0;
    repeat (40) @(posedge pclk);
    `CHK("hiz held", 1'b1, pump_hiz)
    run <= 1'b1;
    seen = 1'b0;
    repeat (100) begin
      @(posedge pclk);
      if (b_counter_reset === 1'b1 && !seen) begin
        seen = 1'b1;
        `CHK("hiz left", 1'b0, pump_hiz)
      end
    end
    `CHK("b reset", 1'b1, seen)
    `CHK("pump free", 1'b1, pump_up & pump_dn)
    $display("test manual done");
  endtask

  task automatic t_gate;
    wr(A_HO, 32'h2);
    wr(A_EX, 32'h110);
    sync_req <= 1'b1;
    repeat (8) @(posedge pclk);
    `CHK("hiz disabled", 1'b0, pump_hiz)
    `CHK("dist ignored", 1'b0, dist_stop)
    sync_req <= 1'b0;
    wr(A_HO, 32'h5);
    wait_per(2);
    `CHK("auto sensed high", 1'b0, pump_hiz)
    run <= 1'b0;
    wr(A_HO, 32'hD);
    repeat (8) @(posedge pclk);
    `CHK("auto hiz on low", 1'b1, pump_hiz)
    run <= 1'b1;
    wr(A_HO, 32'h0);
    $display("test gate done");
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Cycle ceiling guards against a hang
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      finish_test;
    end
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_lock;
    t_pulse(`LP_ALD_N, 1'b0);
    t_pulse(`LP_ALD_P, 1'b1);
    t_cmp;
    t_manual;
    t_gate;
    finish_test;
  end
endmodule // lock_holdover_bench
